// >>> design/lss_cfg.svh
// Purpose: Constants for the LED status selector: offsets, field positions,
//          reset values and timing counts.
// Assumes: 20 MHz core clock.
// Notes:   Definitions only.
`ifndef LSS_CFG_SVH
`define LSS_CFG_SVH

// ----------------------------------------------------------------------
// Bus layout
// ----------------------------------------------------------------------
`define LSS_ADDR_W          4
`define LSS_SEL_OFFSET      4'h0
`define LSS_READ_NONE       32'h00000000

// ----------------------------------------------------------------------
// Selection register fields
// ----------------------------------------------------------------------
`define LSS_BIT_RAW         15
`define LSS_BIT_PSE         7
`define LSS_BIT_RSV         6
`define LSS_BIT_ADDM        5
`define LSS_BIT_TRANSMIT_ACTIVITY_ENABLE        4
`define LSS_BIT_RECEIVE_POLARITY_OK_ENABLE      3
`define LSS_BIT_RECEIVE_ACTIVITY_ENABLE        2
`define LSS_BIT_JABBER_INDICATION_ENABLE        1
`define LSS_BIT_COLLISION_INDICATION_ENABLE        0
`define LSS_SEL_RESET       8'h90
`define LSS_SEL_WR_MASK     8'hBF

// ----------------------------------------------------------------------
// Stretch timing
// ----------------------------------------------------------------------
`define LSS_CLK_HZ           20000000
`define LSS_STRETCH_TIME_MS  10
`define LSS_STRETCH_CYCLES   (`LSS_STRETCH_TIME_MS * (`LSS_CLK_HZ / 1000))
`define LSS_CNT_W            18

`endif

// >>> design/lss_pkg.sv
// Purpose: Types shared by the LED status selector modules.
// Assumes: Nothing beyond the configuration header.
// Notes:   Gray codes from IDLE to LIT to HOLD; HOLD back to IDLE flips both bits.
package lss_pkg;

	// Pulse stretcher states: idle, lit by a live event, holding after it.
	typedef enum logic [1:0] {
		LSS_ST_IDLE = 2'b00,
		LSS_ST_LIT  = 2'b01,
		LSS_ST_HOLD = 2'b11
	} lss_stretch_state_t;

	// Bus slave states: waiting for a request, answering it.
	typedef enum logic [0:0] {
		LSS_BUS_WAIT = 1'b0,
		LSS_BUS_DONE = 1'b1
	} lss_bus_state_t;

endpackage

// >>> design/lss_reg_if.sv
// Purpose: Register access path between the bus slave and the core.
// Assumes: One clock domain.
// Notes:   Write strobe is a one-cycle pulse.
`timescale 1ns/100ps
interface lss_reg_if;
	logic        wr_stb;
	logic [15:0] wr_data;
	logic [1:0]  wr_be;
	logic [15:0] rd_data;

	modport bus  (output wr_stb, output wr_data, output wr_be, input rd_data);
	modport core (input wr_stb, input wr_data, input wr_be, output rd_data);
endinterface

// >>> design/lss_avalon_slave.sv
// Purpose: Avalon-MM slave with waitrequest for the selection register.
// Assumes: Master holds its request until waitrequest is seen low.
// Notes:   Every request is answered one cycle after it appears.
`timescale 1ns/100ps
`include "lss_cfg.svh"
module lss_avalon_slave
	import lss_pkg::*;
(
	input  wire logic                   clk_in,       // Core clock.
	input  wire logic                   rst_in,       // Synchronous reset.
	input  wire logic [`LSS_ADDR_W-1:0] address_in,   // Byte address.
	input  wire logic                   read_in,      // Read request.
	input  wire logic                   write_in,     // Write request.
	input  wire logic [31:0]            writedata_in, // Write data.
	input  wire logic [3:0]             byteenable_in,// Byte lanes.
	output logic      [31:0]            readdata_out, // Read data.
	output logic                        waitrequest_out, // Stall.
	lss_reg_if.bus                      regs          // Core access.
);
	lss_bus_state_t state_q, state_d;
	logic [31:0]    rdata_q, rdata_d;
	logic           hit;

	// Only one word is mapped; others read zero and drop writes.
	assign hit = (address_in == `LSS_SEL_OFFSET);

	// The stall lifts for exactly one cycle per request, so a request
	// that follows back to back is always held for its own answer.
	assign waitrequest_out = (read_in | write_in) & (state_q != LSS_BUS_DONE);
	assign regs.wr_stb     = write_in & (state_q == LSS_BUS_DONE) & hit;
	assign regs.wr_data    = writedata_in[15:0];
	assign regs.wr_be      = byteenable_in[1:0];
	assign readdata_out    = rdata_q;

	// Next state and read data capture.
	always_comb begin
		state_d = LSS_BUS_WAIT;
		rdata_d = rdata_q;
		case (state_q)
			LSS_BUS_WAIT: begin
				if (read_in | write_in) begin
					state_d = LSS_BUS_DONE;
				end
				// Only a read refreshes the data; a write leaves the last read
				// value standing, so the data bus does not toggle needlessly.
				if (read_in) begin
					rdata_d = hit ? {16'h0000, regs.rd_data} : `LSS_READ_NONE;
				end
			end
			LSS_BUS_DONE: state_d = LSS_BUS_WAIT;
			default:      state_d = LSS_BUS_WAIT;
		endcase
	end

	// Registers only.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_q <= LSS_BUS_WAIT;
			rdata_q <= 32'h00000000;
		end else begin
			state_q <= state_d;
			rdata_q <= rdata_d;
		end
	end
endmodule

// >>> design/lss_stretch.sv
// Purpose: Pulse stretcher for the lamp indication.
// Assumes: Raw input is synchronous to the core clock.
// Notes:   Lamp output lags the raw level by one cycle.
`timescale 1ns/100ps
`include "lss_cfg.svh"
module lss_stretch
	import lss_pkg::*;
#(
	parameter logic [`LSS_CNT_W-1:0] HOLD_CYCLES = `LSS_CNT_W'(`LSS_STRETCH_CYCLES)
)(
	input  wire logic clk_in,    // Core clock.
	input  wire logic rst_in,    // Synchronous reset.
	input  wire logic enable_in, // Stretch enabled.
	input  wire logic raw_in,    // Combined indication.
	output logic      lamp_out   // Stretched indication.
);
	lss_stretch_state_t       state_q, state_d;
	logic [`LSS_CNT_W-1:0]    cnt_q, cnt_d;
	logic                     lamp_q, lamp_d;

	assign lamp_out = lamp_q;

	// Each event restarts the hold, so a burst shows as one long glow.
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			LSS_ST_IDLE: if (raw_in) state_d = LSS_ST_LIT;
			LSS_ST_LIT: begin
				if (!raw_in) begin
					if (enable_in) begin
						state_d = LSS_ST_HOLD; // RQ7
						cnt_d   = HOLD_CYCLES - `LSS_CNT_W'(1);
					end else begin
						state_d = LSS_ST_IDLE;
					end
				end
			end
			LSS_ST_HOLD: begin
				if (raw_in) begin
					state_d = LSS_ST_LIT;
				end else if (!enable_in || cnt_q == '0) begin
					state_d = LSS_ST_IDLE;
				end else begin
					cnt_d = cnt_q - `LSS_CNT_W'(1); // RQ9
				end
			end
			default: state_d = LSS_ST_IDLE;
		endcase
		lamp_d = (state_d != LSS_ST_IDLE);
	end

	// Registers only.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_q <= LSS_ST_IDLE;
			cnt_q   <= '0;
			lamp_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			lamp_q  <= lamp_d;
		end
	end
endmodule

// >>> design/lss_led_status_selector.sv
// Purpose: Selection and status logic for the third activity lamp.
// Assumes: Condition inputs are levels synchronous to CORE_CLK_IN.
// Notes:   Lamp output is active high; the pad inverts if needed.
//
// Overview of operation
// RQ1 - Lamp shows the OR of every enabled activity condition.
// RQ2 - Reset enables transmit activity and stretching only; bits 7 and 5..0 stay writable.
// RQ3 - Bit 15 reads the unstretched combined state; writes to it are ignored.
// RQ4 - Bit 6 always reads zero.
// RQ5 - Qualifier bit 5 limits receive activity to address-matched frames.
// RQ6 - Transmit enable includes transmit activity when 1, excludes it when 0.
// RQ7 - Stretch bit 7 lengthens the lamp for each enabled occurrence.
// RQ8 - Enables for polarity ok, receive, jabber and collision add to the lamp.
// RQ9 - Stretch lasts a fixed ten milliseconds so short events stay visible.
`timescale 1ns/100ps
`include "lss_cfg.svh"
module lss_led_status_selector
	import lss_pkg::*;
#(
	parameter logic [`LSS_CNT_W-1:0] STRETCH_CYCLES = `LSS_CNT_W'(`LSS_STRETCH_CYCLES)
)(
	input  wire logic                   CORE_CLK_IN,           // Core clock.
	input  wire logic                   RST_IN,                // Sync reset.
	input  wire logic [`LSS_ADDR_W-1:0] AVS_ADDRESS_IN,        // Byte address.
	input  wire logic                   AVS_READ_IN,           // Read request.
	input  wire logic                   AVS_WRITE_IN,          // Write request.
	input  wire logic [31:0]            AVS_WRITEDATA_IN,      // Write data.
	input  wire logic [3:0]             AVS_BYTEENABLE_IN,     // Byte lanes.
	output logic      [31:0]            AVS_READDATA_OUT,      // Read data.
	output logic                        AVS_WAITREQUEST_OUT,   // Stall.
	input  wire logic                   TRANSMIT_ACTIVITY_IN,  // Transmitting.
	input  wire logic                   RECEIVE_ACTIVITY_IN,   // Receiving.
	input  wire logic                   RX_ADDRESS_MATCH_IN,   // Frame matched.
	input  wire logic                   RX_POLARITY_OK_IN,     // Polarity ok.
	input  wire logic                   JABBER_IN,             // Jabbering.
	input  wire logic                   COLLISION_IN,          // Collision.
	output logic                        THIRD_ACTIVITY_LAMP_PIN_OUT // Lamp.
);
	lss_reg_if regs ();

	logic [7:0] sel_q, sel_d;
	logic       raw_q, raw_d;
	logic       rx_qualified;

	// ----------------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------------

	// Merge a written byte into the writable bits of a stored byte.
	function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
	                                          input logic [7:0] new_v,
	                                          input logic [7:0] mask);
		merge_byte = (old_v & ~mask) | (new_v & mask);
	endfunction

	// One gated condition.
	function automatic logic gate(input logic en, input logic cond);
		gate = en & cond;
	endfunction

	// ----------------------------------------------------------------------
	// Register access
	// ----------------------------------------------------------------------
	lss_avalon_slave u_bus (
		.clk_in          (CORE_CLK_IN),
		.rst_in          (RST_IN),
		.address_in      (AVS_ADDRESS_IN),
		.read_in         (AVS_READ_IN),
		.write_in        (AVS_WRITE_IN),
		.writedata_in    (AVS_WRITEDATA_IN),
		.byteenable_in   (AVS_BYTEENABLE_IN),
		.readdata_out    (AVS_READDATA_OUT),
		.waitrequest_out (AVS_WAITREQUEST_OUT),
		.regs            (regs)
	);

	// Read view: raw state on top, reserved bits as zero.
	assign regs.rd_data = {raw_q, 7'h00, sel_q}; // RQ3 RQ4

	// Only the low lane holds writable bits; the upper lane is status and
	// reserved space, so writes there change nothing.
	always_comb begin
		sel_d = sel_q;
		if (regs.wr_stb && regs.wr_be[0]) begin
			sel_d = merge_byte(sel_q, regs.wr_data[7:0], `LSS_SEL_WR_MASK); // RQ2 RQ3 RQ4
		end
	end

	// ----------------------------------------------------------------------
	// Condition combining
	// ----------------------------------------------------------------------

	// Receive counts only for matched frames while the qualifier is set.
	assign rx_qualified = RECEIVE_ACTIVITY_IN &
	                      (~sel_q[`LSS_BIT_ADDM] | RX_ADDRESS_MATCH_IN); // RQ5

	// Registered so the readback and the lamp see one settled value.
	always_comb begin
		raw_d = gate(sel_q[`LSS_BIT_TRANSMIT_ACTIVITY_ENABLE], TRANSMIT_ACTIVITY_IN) |  // RQ6
		        gate(sel_q[`LSS_BIT_RECEIVE_POLARITY_OK_ENABLE], RX_POLARITY_OK_IN) |   // RQ8
		        gate(sel_q[`LSS_BIT_RECEIVE_ACTIVITY_ENABLE], rx_qualified) |          // RQ8
		        gate(sel_q[`LSS_BIT_JABBER_INDICATION_ENABLE], JABBER_IN) |             // RQ8
		        gate(sel_q[`LSS_BIT_COLLISION_INDICATION_ENABLE], COLLISION_IN);           // RQ1 RQ8
	end

	// Selection and raw state registers.
	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			sel_q <= `LSS_SEL_RESET; // RQ2
			raw_q <= 1'b0;
		end else begin
			sel_q <= sel_d;
			raw_q <= raw_d;
		end
	end

	// ----------------------------------------------------------------------
	// Lamp drive
	// ----------------------------------------------------------------------

	// With stretching off the lamp simply follows the raw state.
	lss_stretch #(
		.HOLD_CYCLES (STRETCH_CYCLES)
	) u_stretch (
		.clk_in    (CORE_CLK_IN),
		.rst_in    (RST_IN),
		.enable_in (sel_q[`LSS_BIT_PSE]), // RQ7
		.raw_in    (raw_q),
		.lamp_out  (THIRD_ACTIVITY_LAMP_PIN_OUT)
	);
endmodule

// >>> bench/lss_sel_assertions.sv
// Purpose: Port-level checks for the LED status selector.
// Assumes: Sees only the top module ports; one clock domain.
// Notes:   Bound to the top module at the foot of this file.
`timescale 1ns/100ps
`include "lss_cfg.svh"
module lss_sel_assertions #(
	parameter logic [`LSS_CNT_W-1:0] STRETCH_CYCLES = `LSS_CNT_W'(8)
)(
	input wire logic        CORE_CLK_IN,                 // Clock.
	input wire logic        RST_IN,                      // Reset.
	input wire logic        AVS_READ_IN,                 // Read.
	input wire logic        AVS_WRITE_IN,                // Write.
	input wire logic [31:0] AVS_READDATA_OUT,            // Read data.
	input wire logic        AVS_WAITREQUEST_OUT,         // Stall.
	input wire logic        TRANSMIT_ACTIVITY_IN,        // Transmit.
	input wire logic        RECEIVE_ACTIVITY_IN,         // Receive.
	input wire logic        RX_POLARITY_OK_IN,           // Polarity.
	input wire logic        JABBER_IN,                   // Jabber.
	input wire logic        COLLISION_IN,                // Collision.
	input wire logic        THIRD_ACTIVITY_LAMP_PIN_OUT  // Lamp.
);
	logic                any_c;
	logic [`LSS_CNT_W:0] quiet_q;
	logic [`LSS_CNT_W:0] quiet_d;

	// Any condition present, whether enabled or not.
	assign any_c = TRANSMIT_ACTIVITY_IN | RECEIVE_ACTIVITY_IN | RX_POLARITY_OK_IN
		| JABBER_IN | COLLISION_IN;

	// Quiet-cycle count; saturates so it never wraps back to a small value.
	always_comb begin
		quiet_d = quiet_q;
		if (any_c) quiet_d = '0;
		else if (quiet_q < STRETCH_CYCLES + 9) quiet_d = quiet_q + 1'b1;
	end

	// Register the quiet count.
	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) quiet_q <= '0;
		else quiet_q <= quiet_d;
	end

	// ----
	// Checks
	// ----
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (RST_IN);

	a_wait_first: assert property ($rose(AVS_READ_IN | AVS_WRITE_IN) |-> AVS_WAITREQUEST_OUT)
		else $error("new request not stalled");
	a_wait_once: assert property ((AVS_READ_IN | AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
		|=> !AVS_WAITREQUEST_OUT) else $error("more than one wait cycle");
	a_idle_ready: assert property (!(AVS_READ_IN | AVS_WRITE_IN) |-> !AVS_WAITREQUEST_OUT)
		else $error("stall without request");
	a_rsv_zero: assert property ((AVS_READDATA_OUT & 32'hFFFF7F40) == 32'h00000000)
		else $error("reserved read bits set");
	a_rdata_hold: assert property (!(AVS_READ_IN && AVS_WAITREQUEST_OUT)
		|=> $stable(AVS_READDATA_OUT)) else $error("read data changed unasked");
	a_lamp_quiet: assert property (quiet_q > STRETCH_CYCLES + 4 |-> !THIRD_ACTIVITY_LAMP_PIN_OUT)
		else $error("lamp lit with no activity");
	a_lamp_cause: assert property ($rose(THIRD_ACTIVITY_LAMP_PIN_OUT) |-> $past(any_c, 2))
		else $error("lamp rose without a condition");
	a_reset_clear: assert property ($fell(RST_IN) |-> !THIRD_ACTIVITY_LAMP_PIN_OUT
		&& AVS_READDATA_OUT == 32'h00000000) else $error("outputs not cleared by reset");
endmodule

bind lss_led_status_selector lss_sel_assertions #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_chk (
	.CORE_CLK_IN, .RST_IN, .AVS_READ_IN, .AVS_WRITE_IN, .AVS_READDATA_OUT,
	.AVS_WAITREQUEST_OUT, .TRANSMIT_ACTIVITY_IN, .RECEIVE_ACTIVITY_IN, .RX_POLARITY_OK_IN,
	.JABBER_IN, .COLLISION_IN, .THIRD_ACTIVITY_LAMP_PIN_OUT);

// >>> bench/tb_lss_led_status_selector.sv
// Purpose: Self-checking bench for the LED status selector.
// Assumes: Stretch shortened to 8 cycles so the run stays brief.
// Notes:   Condition bits follow the enable bit order 4..0.
`timescale 1ns/100ps
`include "lss_cfg.svh"
module tb_lss_led_status_selector;
	logic        clk, rst, rd, wr, am, lamp, wt;
	logic [3:0]  addr, be;
	logic [31:0] wd, rdat, q;
	logic [4:0]  cond;
	int          fail_count, compares, i;

	lss_led_status_selector #(.STRETCH_CYCLES(18'd8)) u_dut (
		.CORE_CLK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
		.AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(be),
		.AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wt), .TRANSMIT_ACTIVITY_IN(cond[4]),
		.RX_POLARITY_OK_IN(cond[3]), .RECEIVE_ACTIVITY_IN(cond[2]), .JABBER_IN(cond[1]),
		.COLLISION_IN(cond[0]), .RX_ADDRESS_MATCH_IN(am), .THIRD_ACTIVITY_LAMP_PIN_OUT(lamp));

	// 20 MHz core clock.
	always #25 clk = ~clk;

	// ----
	// Tasks
	// ----
	task automatic complete_run;
		if (fail_count == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask

	// Lamp is looked at just after an edge, once that edge's updates have landed.
	task automatic chk_lamp(input logic e, input int n);
		repeat (n) @(posedge clk);
		#1 chk("lamp", {31'h0, e}, {31'h0, lamp});
	endtask

	// Holds the request until waitrequest is sampled low; only the watchdog ends a hang.
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		rd <= !w;
		wr <= w;
		do begin
			@(posedge clk);
		end while (wt !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic rdreg(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk("register", e, q);
	endtask

	// Watchdog: the tests need under 150 cycles, so 2000 means a hang.
	initial begin
		#100000;
		fail_count++;
		complete_run();
	end

	// Main sequence.
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		rd = 1'b0;
		wr = 1'b0;
		am = 1'b0;
		addr = 4'h0;
		be = 4'hF;
		wd = 32'h0;
		cond = 5'h00;
		fail_count = 0;
		compares = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rdreg(4'h0, 32'h00000090);
		bus(1'b1, 4'h0, 32'hFFFFFFFF);
		rdreg(4'h0, 32'h000000BF);
		bus(1'b1, 4'h4, 32'h00000000);
		rdreg(4'h4, 32'h00000000);
		// A write without the low byte lane must leave the selection alone.
		be <= 4'hE;
		bus(1'b1, 4'h0, 32'h00000000);
		be <= 4'hF;
		rdreg(4'h0, 32'h000000BF);
		// Each enable alone, then every other condition with it cleared.
		for (i = 0; i < 5; i++) begin
			bus(1'b1, 4'h0, 32'(1 << i));
			cond <= 5'(1 << i);
			chk_lamp(1'b1, 3);
			rdreg(4'h0, 32'h8000 | 32'(1 << i));
			cond <= ~5'(1 << i);
			chk_lamp(1'b0, 3);
		end
		bus(1'b1, 4'h0, 32'h00000024);
		cond <= 5'h04;
		chk_lamp(1'b0, 3);
		@(posedge clk);
		am <= 1'b1;
		chk_lamp(1'b1, 3);
		// One-cycle transmit pulse with and without stretching.
		for (i = 0; i < 2; i++) begin
			bus(1'b1, 4'h0, i ? 32'h10 : 32'h90);
			cond <= 5'h10;
			@(posedge clk);
			cond <= 5'h00;
			chk_lamp(i == 0, 6);
			rdreg(4'h0, i ? 32'h10 : 32'h90);
			chk_lamp(1'b0, 8);
		end
		complete_run();
	end
endmodule
